// File: core/sram_block_with_fifo_control.sv
// What this block does
// - 4608-bit store, five aspect ratios.
// - Independent read and write ports, separate widths outside queue mode.
// - Outside queue mode, data written at one width reads at another.
// - Whole rows preloadable at initialisation.
// - Built-in queue controller, no outside logic.
// - Queue width and depth set by configuration.
// - Empty, full, almost-empty, almost-full outputs.
// - Counters form read and write pointers.
// - Flags and ports serve one block only; there are no cascade ports.
`include "sram_fifo_defines.svh"
module sram_block_with_fifo_control
   import sram_fifo_pkg::*;
#(
   parameter int ROWS = 256
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB register slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Write port
   input wire logic wr_en,
   input wire logic [11:0] wr_addr,
   input wire logic [17:0] wr_data,
   // Read port
   input wire logic rd_en,
   input wire logic [11:0] rd_addr,
   output logic [17:0] rd_data,
   // Initialisation load from flash or the user test port macro
   input wire logic init_wr,
   input wire logic [7:0] init_row,
   input wire logic [17:0] init_word,
   // Queue flags and interrupt
   output logic empty,
   output logic full,
   output logic almost_empty_flag,
   output logic almost_full_flag,
   output logic irq
);
   // The row index is eight bits wide, so no other row count can be addressed.
   if (ROWS != 256) begin : g_rows_check
      $error("ROWS must be 256 for the fixed aspect-ratio mapping");
   end

   logic [17:0] mem [0:ROWS-1];
   ctl_state_t s_reg;
   ctl_state_t s_next;

   function automatic logic [12:0] capacity(input logic [2:0] m);
      logic [12:0] c;
      c = 13'h1000;
      unique case (m)
         W_X2: c = 13'h0800;
         W_X4: c = 13'h0400;
         W_X9: c = 13'h0200;
         W_X18: c = 13'h0100;
         default: c = 13'h1000;
      endcase
      return c;
   endfunction

   // Codes 4 bits and narrower pack into the low 16 bits of a row, so only
   // the x9 and x18 shapes reach the two extra bits of each row.
   function automatic loc_t locate(input logic [2:0] m, input logic [11:0] a);
      loc_t l;
      l.row = a[11:4];
      l.sh = {1'b0, a[3:0]};
      l.mask = 18'h00001;
      unique case (m)
         W_X2: begin
            l.row = a[10:3];
            l.sh = {1'b0, a[2:0], 1'b0};
            l.mask = 18'h00003;
         end
         W_X4: begin
            l.row = a[9:2];
            l.sh = {1'b0, a[1:0], 2'b00};
            l.mask = 18'h0000F;
         end
         W_X9: begin
            l.row = a[8:1];
            l.sh = a[0] ? 5'h09 : 5'h00;
            l.mask = 18'h001FF;
         end
         W_X18: begin
            l.row = a[7:0];
            l.sh = 5'h00;
            l.mask = 18'h3FFFF;
         end
         default: begin
            l.row = a[11:4];
            l.sh = {1'b0, a[3:0]};
            l.mask = 18'h00001;
         end
      endcase
      l.mask = l.mask << l.sh;
      return l;
   endfunction

   function automatic logic [12:0] depth_of(input logic [2:0] m, input logic [12:0] d);
      logic [12:0] c;
      c = capacity(m);
      return ((d == 13'h0000) || (d > c)) ? c : d;
   endfunction

   logic setup;
   logic apb_wr;
   logic cfg_flush;
   logic [12:0] dep_cur;
   logic [12:0] dep_nxt;
   logic push;
   logic pop;
   logic mem_we;
   logic mem_re;
   loc_t wl;
   loc_t rl;
   logic [4:0] ev;
   logic [4:0] w1c;
   logic [17:0] row_rd;

   always_comb begin
      s_next = s_reg;
      setup = psel && !penable;
      apb_wr = psel && penable && pwrite;
      cfg_flush = 1'b0;
      w1c = 5'h00;
      if (apb_wr) begin
         unique case (paddr)
            `SF_OFF_CTRL: begin
               s_next.fifo_mode = pwdata[`SF_CTRL_FIFO_BIT];
               s_next.wr_width = pwdata[`SF_CTRL_WRW_LSB +: 3];
               s_next.rd_width = pwdata[`SF_CTRL_RDW_LSB +: 3];
               cfg_flush = 1'b1;
            end
            `SF_OFF_DEPTH: begin
               s_next.depth = pwdata[12:0];
               cfg_flush = 1'b1;
            end
            `SF_OFF_AE_THR: s_next.ae_thr = pwdata[12:0];
            `SF_OFF_AF_THR: s_next.af_thr = pwdata[12:0];
            `SF_OFF_IRQ_STAT: w1c = pwdata[`SF_IRQ_W-1:0];
            `SF_OFF_IRQ_MASK: s_next.irq_mask = pwdata[`SF_IRQ_W-1:0];
            default: ;
         endcase
      end
      // Read data is captured in the setup cycle so that a zero-wait access
      // phase still presents it from a flip-flop.
      if (setup) begin
         s_next.prdata = 32'h00000000;
         s_next.pslverr = 1'b0;
         unique case (paddr)
            `SF_OFF_CTRL: s_next.prdata = {25'h0, s_reg.rd_width, s_reg.wr_width,
               s_reg.fifo_mode};
            `SF_OFF_DEPTH: s_next.prdata = {19'h0, s_reg.depth};
            `SF_OFF_AE_THR: s_next.prdata = {19'h0, s_reg.ae_thr};
            `SF_OFF_AF_THR: s_next.prdata = {19'h0, s_reg.af_thr};
            `SF_OFF_STAT: s_next.prdata = {12'h0, s_reg.af, s_reg.ae, s_reg.full,
               s_reg.empty, 3'h0, s_reg.count};
            `SF_OFF_IRQ_STAT: s_next.prdata = {27'h0, s_reg.irq_stat};
            `SF_OFF_IRQ_MASK: s_next.prdata = {27'h0, s_reg.irq_mask};
            default: s_next.pslverr = 1'b1;
         endcase
      end

      // The queue uses the write-port width on both ports.
      dep_cur = depth_of(s_reg.wr_width, s_reg.depth);
      dep_nxt = depth_of(s_next.wr_width, s_next.depth);
      push = s_reg.fifo_mode && wr_en && !s_reg.full && !init_wr;
      pop = s_reg.fifo_mode && rd_en && !s_reg.empty;
      if (s_reg.fifo_mode) begin
         wl = locate(s_reg.wr_width, s_reg.wr_ptr);
         rl = locate(s_reg.wr_width, s_reg.rd_ptr);
         mem_we = push;
         mem_re = pop;
      end else begin
         wl = locate(s_reg.wr_width, wr_addr);
         rl = locate(s_reg.rd_width, rd_addr);
         mem_we = wr_en && !init_wr;
         mem_re = rd_en;
      end
      row_rd = mem[rl.row];
      if (mem_re) begin
         s_next.rd_data = (row_rd & rl.mask) >> rl.sh;
      end

      if (cfg_flush) begin
         s_next.wr_ptr = 12'h000;
         s_next.rd_ptr = 12'h000;
         s_next.count = 13'h0000;
      end else begin
         if (push) begin
            s_next.wr_ptr = (s_reg.wr_ptr == 12'(dep_cur - 13'h1)) ? 12'h000 :
               s_reg.wr_ptr + 12'h001;
         end
         if (pop) begin
            s_next.rd_ptr = (s_reg.rd_ptr == 12'(dep_cur - 13'h1)) ? 12'h000 :
               s_reg.rd_ptr + 12'h001;
         end
         if (push && !pop) begin
            s_next.count = s_reg.count + 13'h0001;
         end else if (pop && !push) begin
            s_next.count = s_reg.count - 13'h0001;
         end
      end
      s_next.empty = s_next.count == 13'h0000;
      s_next.full = s_next.count >= dep_nxt;
      s_next.ae = s_next.count <= s_next.ae_thr;
      s_next.af = s_next.count >= s_next.af_thr;

      ev = 5'h00;
      ev[`SF_IRQ_OVF] = s_reg.fifo_mode && wr_en && s_reg.full;
      ev[`SF_IRQ_UDF] = s_reg.fifo_mode && rd_en && s_reg.empty;
      ev[`SF_IRQ_FULL] = s_reg.fifo_mode && s_next.full && !s_reg.full;
      ev[`SF_IRQ_AF] = s_reg.fifo_mode && s_next.af && !s_reg.af;
      ev[`SF_IRQ_AE] = s_reg.fifo_mode && s_next.ae && !s_reg.ae;
      // A new event outweighs a clear in the same cycle.
      s_next.irq_stat = (s_reg.irq_stat & ~w1c) | ev;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_reg <= '0;
         s_reg.wr_width <= W_X18;
         s_reg.rd_width <= W_X18;
         s_reg.depth <= `SF_RST_DEPTH;
         s_reg.ae_thr <= `SF_RST_AE_THR;
         s_reg.af_thr <= `SF_RST_AF_THR;
         s_reg.empty <= 1'b1;
         s_reg.ae <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Initialisation loads have priority; a user write in the same cycle is lost.
   always_ff @(posedge clk) begin
      if (init_wr) begin
         mem[init_row] <= init_word;
      end else if (mem_we) begin
         mem[wl.row] <= (mem[wl.row] & ~wl.mask) | ((wr_data << wl.sh) & wl.mask);
      end
   end

   assign prdata = s_reg.prdata;
   assign pready = 1'b1;
   assign pslverr = s_reg.pslverr && psel && penable;
   assign rd_data = s_reg.rd_data;
   assign empty = s_reg.empty;
   assign full = s_reg.full;
   assign almost_empty_flag = s_reg.ae;
   assign almost_full_flag = s_reg.af;
   assign irq = |(s_reg.irq_stat & s_reg.irq_mask);

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_full_blocks_push: assert property (full && wr_en && !rd_en && !cfg_flush |=>
      s_reg.count == $past(s_reg.count) && s_reg.wr_ptr == $past(s_reg.wr_ptr))
      else $error("write accepted while full");
   a_empty_blocks_pop: assert property (empty && rd_en && !wr_en && !cfg_flush |=>
      s_reg.count == $past(s_reg.count) && s_reg.rd_ptr == $past(s_reg.rd_ptr))
      else $error("read accepted while empty");
   a_empty_flag_count: assert property (empty == (s_reg.count == 13'h0000))
      else $error("empty flag disagrees with count");
   a_full_flag_depth: assert property (!$past(sys_rst) |->
      full == (s_reg.count >= depth_of(s_reg.wr_width, s_reg.depth)))
      else $error("full flag disagrees with depth");
   a_almost_empty_thr: assert property (!$past(sys_rst) |->
      almost_empty_flag == (s_reg.count <= s_reg.ae_thr))
      else $error("almost empty flag wrong");
   a_almost_full_thr: assert property (!$past(sys_rst) |->
      almost_full_flag == (s_reg.count >= s_reg.af_thr))
      else $error("almost full flag wrong");
   a_wr_ptr_step: assert property (push && !cfg_flush &&
      s_reg.wr_ptr != 12'(dep_cur - 13'h1) |=> s_reg.wr_ptr == $past(s_reg.wr_ptr) + 12'h001)
      else $error("write pointer did not advance");
   a_count_bound: assert property (s_reg.count <= capacity(s_reg.wr_width))
      else $error("count beyond block capacity");
   a_push_pop_count: assert property (push && pop && !cfg_flush |=>
      $stable(s_reg.count) ##1 1'b1)
      else $error("simultaneous push and pop changed count");
   a_irq_level: assert property (irq == |(s_reg.irq_stat & s_reg.irq_mask))
      else $error("interrupt level wrong");
   a_ovf_cause: assert property ($rose(s_reg.irq_stat[`SF_IRQ_OVF]) |->
      $past(wr_en && full && s_reg.fifo_mode))
      else $error("overflow flagged without a write while full");
   a_rd_ptr_step: assert property (pop && !cfg_flush &&
      s_reg.rd_ptr != 12'(dep_cur - 13'h1) |=> s_reg.rd_ptr == $past(s_reg.rd_ptr) + 12'h001)
      else $error("read pointer did not advance");
   a_wr_ptr_wrap: assert property (push && !cfg_flush &&
      s_reg.wr_ptr == 12'(dep_cur - 13'h1) |=> s_reg.wr_ptr == 12'h000)
      else $error("write pointer did not wrap at the depth");
   a_flush_clears: assert property (cfg_flush |=>
      s_reg.count == 13'h0000 && s_reg.wr_ptr == 12'h000 && s_reg.rd_ptr == 12'h000)
      else $error("configuration write did not empty the queue");
endmodule

// File: include/sram_fifo_defines.svh
`ifndef SRAM_FIFO_DEFINES_SVH
`define SRAM_FIFO_DEFINES_SVH
`define SF_OFF_CTRL 12'h000
`define SF_OFF_DEPTH 12'h004
`define SF_OFF_AE_THR 12'h008
`define SF_OFF_AF_THR 12'h00C
`define SF_OFF_STAT 12'h010
`define SF_OFF_IRQ_STAT 12'h014
`define SF_OFF_IRQ_MASK 12'h018
`define SF_CTRL_FIFO_BIT 0
`define SF_CTRL_WRW_LSB 1
`define SF_CTRL_RDW_LSB 4
`define SF_STAT_EMPTY_BIT 16
`define SF_STAT_FULL_BIT 17
`define SF_STAT_AE_BIT 18
`define SF_STAT_AF_BIT 19
`define SF_RST_DEPTH 13'h1000
`define SF_RST_AE_THR 13'h0000
`define SF_RST_AF_THR 13'h1000
`define SF_IRQ_OVF 0
`define SF_IRQ_UDF 1
`define SF_IRQ_FULL 2
`define SF_IRQ_AF 3
`define SF_IRQ_AE 4
`define SF_IRQ_W 5
`endif

// File: include/sram_fifo_pkg.sv
package sram_fifo_pkg;
   typedef enum logic [2:0] {
      W_X1 = 3'b000,
      W_X2 = 3'b001,
      W_X4 = 3'b010,
      W_X9 = 3'b011,
      W_X18 = 3'b100
   } width_mode_t;

   typedef struct packed {
      logic [7:0] row;
      logic [4:0] sh;
      logic [17:0] mask;
   } loc_t;

   typedef struct packed {
      logic fifo_mode;
      logic [2:0] wr_width;
      logic [2:0] rd_width;
      logic [12:0] depth;
      logic [12:0] ae_thr;
      logic [12:0] af_thr;
      logic [4:0] irq_stat;
      logic [4:0] irq_mask;
      logic [11:0] wr_ptr;
      logic [11:0] rd_ptr;
      logic [12:0] count;
      logic empty;
      logic full;
      logic ae;
      logic af;
      logic [17:0] rd_data;
      logic [31:0] prdata;
      logic pslverr;
   } ctl_state_t;
endpackage

// File: verif/fabric_user_model.sv
module fabric_user_model (
   // Clock
   input wire logic clk,
   // Requests from the bench
   input wire logic push_req,
   input wire logic pull_req,
   input wire logic [11:0] addr,
   input wire logic [17:0] data,
   // Memory ports
   output logic wr_en,
   output logic [11:0] wr_addr,
   output logic [17:0] wr_data,
   output logic rd_en,
   output logic [11:0] rd_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] last_reg = 18'h00000;
   always_ff @(posedge clk) begin
      if (push_req) begin
         last_reg <= data;
      end
   end
   // An idle data bus shows the inverse of its last word, so a stale value never matches.
   assign wr_data = push_req ? data : ~last_reg;
   assign wr_en = push_req;
   assign rd_en = pull_req;
   assign wr_addr = addr;
   assign rd_addr = addr;
endmodule

// File: verif/sram_block_with_fifo_control_tb.sv
`include "sram_fifo_defines.svh"
module sram_block_with_fifo_control_tb;
   import sram_fifo_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, push_req, pull_req;
   logic wr_en, rd_en, init_wr, empty, full, almost_empty_flag, almost_full_flag;
   logic [11:0] paddr, addr, wr_addr, rd_addr;
   logic [31:0] pwdata, prdata, rv;
   logic [17:0] data, wr_data, rd_data, init_word;
   logic [7:0] init_row;
   logic [3:0] flags;
   assign flags = {empty, full, almost_empty_flag, almost_full_flag};
   int fail_count = 0;
   int comparisons = 0;
   sram_block_with_fifo_control #(.ROWS(256)) DUT (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .init_wr(init_wr), .init_row(init_row), .init_word(init_word),
      .empty(empty), .full(full), .almost_empty_flag(almost_empty_flag),
      .almost_full_flag(almost_full_flag), .irq(irq));
   fabric_user_model user_side (.clk(clk), .push_req(push_req), .pull_req(pull_req),
      .addr(addr), .data(data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_en(rd_en), .rd_addr(rd_addr));
   task automatic finish_test;
      if (fail_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fail_count++;
         finish_test;
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic e;
      apb(1'b1, a, d, rv, e);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic e;
      apb(1'b0, a, 32'h00000000, rv, e);
      chk(rv, exp);
   endtask
   // Flags and read data are looked at one edge after the edge that took the request.
   task automatic port(input logic w, input logic r, input logic [11:0] a,
                       input logic [17:0] d);
      @(posedge clk);
      push_req <= w;
      pull_req <= r;
      addr <= a;
      data <= d;
      @(posedge clk);
      push_req <= 1'b0;
      pull_req <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_reset;
      logic e;
      chk({27'h0, empty, full, almost_empty_flag, almost_full_flag, irq}, 32'h14);
      rdc(`SF_OFF_CTRL, 32'h48);
      rdc(`SF_OFF_AF_THR, 32'h1000);
      rdc(`SF_OFF_STAT, 32'h50000);
      apb(1'b0, 12'h020, 32'h00000000, rv, e);
      chk(rv, 32'h00000000);
      chk({31'h0, e}, 32'h00000001);
   endtask
   task automatic t_ram;
      @(posedge clk);
      init_wr <= 1'b1;
      init_row <= 8'h07;
      init_word <= 18'h25A5A;
      @(posedge clk);
      init_wr <= 1'b0;
      port(1'b0, 1'b1, 12'h007, 18'h00000);
      chk(rd_data, 32'h25A5A);
      port(1'b1, 1'b0, 12'h0FF, 18'h3FFFF);
      port(1'b1, 1'b0, 12'h000, 18'h12345);
      port(1'b0, 1'b1, 12'h0FF, 18'h00000);
      chk(rd_data, 32'h3FFFF);
      wr(`SF_OFF_CTRL, 32'h04);
      port(1'b1, 1'b0, 12'h005, 18'h0000A);
      for (int i = 0; i < 4; i++) begin
         port(1'b0, 1'b1, 12'd20 + 12'(i), 18'h00000);
         chk(rd_data, 32'((4'hA >> i) & 4'h1));
      end
      wr(`SF_OFF_CTRL, 32'h36);
      port(1'b1, 1'b0, 12'h011, 18'h001AB);
      port(1'b1, 1'b0, 12'h010, 18'h000CD);
      port(1'b0, 1'b1, 12'h011, 18'h00000);
      chk(rd_data, 32'h1AB);
      port(1'b0, 1'b1, 12'h010, 18'h00000);
      chk(rd_data, 32'h0CD);
      wr(`SF_OFF_CTRL, 32'h02);
      port(1'b1, 1'b0, 12'h00A, 18'h00002);
      port(1'b0, 1'b1, 12'h015, 18'h00000);
      chk(rd_data, 32'h1);
      port(1'b0, 1'b1, 12'h014, 18'h00000);
      chk(rd_data, 32'h0);
   endtask
   task automatic t_fifo;
      wr(`SF_OFF_CTRL, 32'h09);
      wr(`SF_OFF_DEPTH, 32'h4);
      wr(`SF_OFF_AE_THR, 32'h1);
      wr(`SF_OFF_AF_THR, 32'h3);
      wr(`SF_OFF_IRQ_MASK, 32'h1F);
      wr(`SF_OFF_IRQ_STAT, 32'h1F);
      for (int k = 1; k <= 4; k++) begin
         port(1'b1, 1'b0, 12'h000, 18'h00100 + 18'(k));
         chk(flags, {1'b0, k == 4, k <= 1, k >= 3});
      end
      port(1'b1, 1'b0, 12'h000, 18'h3FFFF);
      rdc(`SF_OFF_STAT, 32'hA0004);
      wr(`SF_OFF_STAT, 32'hFFFFFFFF);
      rdc(`SF_OFF_STAT, 32'hA0004);
      rdc(`SF_OFF_IRQ_STAT, 32'h0D);
      chk(irq, 1);
      wr(`SF_OFF_IRQ_MASK, 32'h0);
      @(posedge clk);
      chk(irq, 0);
      wr(`SF_OFF_IRQ_STAT, 32'h1F);
      rdc(`SF_OFF_IRQ_STAT, 32'h0);
      for (int k = 1; k <= 4; k++) begin
         port(1'b0, 1'b1, 12'h000, 18'h00000);
         chk(rd_data, 32'h100 + 32'(k));
         chk(flags, {k == 4, 1'b0, k >= 3, k <= 1});
      end
      port(1'b0, 1'b1, 12'h000, 18'h00000);
      chk(rd_data, 32'h104);
      rdc(`SF_OFF_IRQ_STAT, 32'h12);
      wr(`SF_OFF_IRQ_MASK, 32'h2);
      @(posedge clk);
      chk(irq, 1);
      port(1'b1, 1'b0, 12'h000, 18'h00111);
      port(1'b1, 1'b1, 12'h000, 18'h00222);
      chk(rd_data, 32'h111);
      rdc(`SF_OFF_STAT, 32'h40001);
      port(1'b0, 1'b1, 12'h000, 18'h00000);
      chk(rd_data, 32'h222);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      sys_rst = 1'b1;
      {psel, penable, pwrite, push_req, pull_req, init_wr} = 6'h00;
      {paddr, addr, pwdata, data, init_word, init_row} = '0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_ram;
      t_fifo;
      finish_test;
   end
   initial begin
      #200000;
      fail_count++;
      finish_test;
   end
endmodule
